// *** parameter_channel_request_decoder_tb.sv ***
// Self-checking bench: APB-driven controller joined to the device end
`timescale 1ns/10ps
`include "pcr_consts.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end
module parameter_channel_request_decoder_tb;
   import pcr_pkg::*;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   pcr_rx_t rx_words = '0;
   pcr_word_t tg_sel;
   pcr_word_t ext_sel;
   pcr_map_t send_map;
   logic free_mode;
   int num_errors = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'h0000_003C;
   pcr_word_t m_tg = 16'h0001;
   pcr_word_t m_ext = 16'h0001;
   pcr_map_t m_map = '0;
   int m_nerr;
   logic [15:0] m_err;
   // 125 MHz clock
   always #4 clk_in = ~clk_in;
   // Both ends face each other; checker watches the link
   pcr_if i_pcr_if();
   pcr_controller i_pcr_controller (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .chan(i_pcr_if));
   pcr_device i_pcr_device (.clk_in(clk_in), .reset_in(reset_in), .chan(i_pcr_if), .rx_words_in(rx_words),
      .tg_sel_out(tg_sel), .ext_sel_out(ext_sel), .send_map_out(send_map), .free_mode_out(free_mode));
   pcr_assertions i_pcr_assertions (.clk_in(clk_in), .reset_in(reset_in), .req_valid(i_pcr_if.req_valid),
      .req_words(i_pcr_if.req_words), .resp_valid(i_pcr_if.resp_valid), .resp_words(i_pcr_if.resp_words));
   // Repeatable xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic timeout(input int n, input int lim);
      if (n >= lim) begin
         num_errors++;
         $display("ERROR at %0t: wait ran out", $time);
         final_report();
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      int n;
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      timeout(n, 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Load four words, start, wait for done, fetch the answer
   task automatic req(input pcr_chan_t w, output pcr_chan_t r);
      logic [31:0] q;
      logic e;
      int n;
      for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 * i), {16'h0000, w[i]}, q, e);
      apb(1'b1, `PCR_A_CTRL, 32'h0000_0001, q, e);
      n = 0;
      do begin
         apb(1'b0, `PCR_A_STAT, 32'h0000_0000, q, e);
         n++;
      end while (q[1] !== 1'b1 && n < 20);
      timeout(n, 20);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, `PCR_A_RESP0 + 8'(4 * i), 32'h0000_0000, q, e);
         `CHK(q[31:16], 16'h0000)
         r[i] = q[15:0];
      end
   endtask
   function automatic void flag(input logic [15:0] v);
      m_nerr++;
      m_err = v;
   endfunction
   // Expected answer and device state; ambiguous double faults are flagged by count
   function automatic pcr_chan_t model_resp(input pcr_chan_t w);
      pcr_chan_t x;
      logic [15:0] ofs;
      logic [15:0] num;
      logic [7:0] sub;
      logic wr;
      logic [3:0] base;
      logic pv;
      sub = w[1][15:8];
      wr = (w[0][15:12] == 4'h7);
      pv = 1'b1;
      ofs = 16'h0000;
      case (w[1][7:0])
         8'h00: ofs = 16'h0000;
         8'h80: ofs = 16'h07D0;
         8'h90: ofs = 16'h1770;
         8'h20: ofs = 16'h1F40;
         8'hA0: ofs = 16'h2710;
         8'h50: ofs = 16'h4E20;
         8'hF0: ofs = 16'h7530;
         8'h74: ofs = 16'hEA60;
         default: pv = 1'b0;
      endcase
      num = {5'h00, w[0][10:0]} + ofs;
      case (m_ext)
         16'h0001, 16'h0161: base = 4'h2;
         16'h0014, 16'h0160, 16'h0162: base = 4'h6;
         16'h015E: base = 4'h4;
         16'h03E7: base = 4'h0;
         default: base = 4'hF;
      endcase
      m_nerr = 0;
      m_err = 16'hFFFF;
      if (!(w[0][15:12] inside {4'h6, 4'h7})) flag(16'h006A);
      else if (!pv || !(num inside {16'h039A, 16'h081F, 16'h0802, 16'h0803})) flag(16'h0000);
      else begin
         if (num inside {16'h039A, 16'h081F} && sub != 8'h00) flag(16'h0004);
         if (num inside {16'h0802, 16'h0803} && sub > 8'h07) flag(16'h0003);
         if (wr && num == 16'h0802) flag(16'h0001);
         if (wr && num == 16'h081F && m_tg != 16'h03E7) flag(16'h0001);
         if (wr && num == 16'h081F && !(w[3] inside {16'h0001, 16'h0014, 16'h015E, 16'h0160, 16'h0161,
            16'h0162, 16'h03E7})) flag(16'h0014);
         if (wr && num == 16'h0803 && (m_tg != 16'h03E7 || sub < {4'h0, base})) flag(16'h0001);
         if (wr && num == 16'h0803 && w[3][15:10] != 6'h3F) flag(16'h0005);
      end
      x = w;
      if (m_err != 16'hFFFF) begin
         x[0][15:12] = 4'h7;
         x[2] = m_err;
         x[3] = 16'h0000;
      end else if (wr) begin
         x[0][15:12] = 4'h4;
         if (num == 16'h039A) m_tg = w[3];
         if (num == 16'h081F) m_ext = w[3];
         if (num == 16'h0803) m_map[sub[2:0]] = {w[2], 6'h00, w[3][9:0]};
      end else begin
         x[0][15:12] = 4'h5;
         // Word 2 carries the high half of the value, word 3 the low half
         {x[2], x[3]} = (num == 16'h039A) ? {16'h0000, m_tg} : (num == 16'h081F) ? {16'h0000, m_ext} :
            (num == 16'h0802) ? {16'h0000, rx_words[sub[2:0]]} : m_map[sub[2:0]];
      end
      return x;
   endfunction
   task automatic run(input pcr_chan_t w);
      pcr_chan_t got;
      pcr_chan_t exp;
      req(w, got);
      exp = model_resp(w);
      if (m_nerr <= 1) `CHK(got, exp)
      else `CHK(got[0][15:12], 4'h7)
      `CHK(tg_sel, m_tg)
      `CHK(ext_sel, m_ext)
      `CHK(free_mode, (m_tg == 16'h03E7))
      `CHK(send_map, m_map)
   endtask
   // Hand-picked cases: lock order, boundaries, every error kind
   pcr_chan_t corners [20] = '{
      '{16'h639A, 16'h0000, 16'h0000, 16'h0000}, '{16'h704F, 16'h0080, 16'h0000, 16'h0014},
      '{16'h739A, 16'h0000, 16'h0000, 16'h03E7}, '{16'h704F, 16'h0080, 16'h0000, 16'h0005},
      '{16'h704F, 16'h0080, 16'h0000, 16'h015E}, '{16'h7033, 16'h0380, 16'h02D2, 16'hFC02},
      '{16'h7033, 16'h0480, 16'h02D2, 16'hFC02}, '{16'h7033, 16'h0580, 16'h0001, 16'h0002},
      '{16'h6033, 16'h0480, 16'h0000, 16'h0000}, '{16'h7032, 16'h0180, 16'h0000, 16'h0001},
      '{16'h6032, 16'h0280, 16'h0000, 16'h0000}, '{16'hA39A, 16'h0000, 16'h0000, 16'h0000},
      '{16'h6001, 16'h0011, 16'h0000, 16'h0000}, '{16'h639A, 16'h0100, 16'h0000, 16'h0000},
      '{16'h6033, 16'h0980, 16'h0000, 16'h0000}, '{16'h604F, 16'h0090, 16'h0000, 16'h0000},
      '{16'h739A, 16'h0000, 16'h0000, 16'h0014}, '{16'h7033, 16'h0780, 16'h0001, 16'hFC05},
      '{16'h6731, 16'h0290, 16'h0000, 16'h0000}, '{16'h604F, 16'h0080, 16'h0000, 16'h0000}};
   pcr_word_t idt [4] = '{16'h039A, 16'h004F, 16'h0032, 16'h0033};
   pcr_word_t vt [8] = '{16'h03E7, 16'h0001, 16'h0014, 16'h015E, 16'h0160, 16'h0161, 16'h0162, 16'h03E7};
   // Main sequence
   initial begin
      pcr_chan_t w;
      logic [31:0] r;
      logic [31:0] s;
      logic [31:0] q;
      logic e;
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      apb(1'b0, 8'h40, 32'h0000_0000, q, e);
      `CHK({e, q}, 33'h1_0000_0000)
      // Table rows list word 0 first; the packed channel type puts word 3 leftmost
      for (int k = 0; k < 20; k++) begin
         w = {<<16{corners[k]}};
         run(w);
      end
      for (int k = 0; k < 200; k++) begin
         r = rnd();
         s = rnd();
         rx_words[r[2:0]] <= s[31:16];
         w[0] = {(r[4:2] == 3'd0) ? r[15:12] : (r[5] ? 4'h6 : 4'h7), idt[r[1:0]][11:0]};
         w[1] = {(r[6] ? 8'h00 : {5'h00, r[9:7]}), ((r[10] && r[11]) ? s[31:24] : (r[1:0] == 2'd0 ? 8'h00 :
            8'h80))};
         w[2] = (r[1:0] == 2'd3) ? s[15:0] : 16'h0000;
         w[3] = (r[1:0] == 2'd3) ? {(r[12] ? 6'h3F : s[21:16]), s[9:0]} : vt[s[2:0]];
         if (w[0][15:12] == 4'h6) w[3:2] = '0;
         run(w);
      end
      final_report();
   end
endmodule // parameter_channel_request_decoder_tb

// *** pcr_assertions.sv ***
// Concurrent checks on the parameter channel between controller and device
`timescale 1ns/10ps
module pcr_assertions (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic req_valid,
   input wire pcr_pkg::pcr_chan_t req_words,
   input wire logic resp_valid,
   input wire pcr_pkg::pcr_chan_t resp_words
);
   import pcr_pkg::*;
   logic [3:0] req_code;
   logic [3:0] resp_code;
   logic page_ok;
   // Field slices; only the eight page codes map to an offset
   assign req_code = req_words[0][15:12];
   assign resp_code = resp_words[0][15:12];
   assign page_ok = req_words[1][7:0] inside {8'h00, 8'h80, 8'h90, 8'h20, 8'hA0, 8'h50, 8'hF0, 8'h74};
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // Handshake timing of one request
   resp_latency_a: assert property ($rose(req_valid) |-> ##2 resp_valid)
      else $error("answer not two cycles after request");
   resp_pulse_a: assert property (resp_valid |=> !resp_valid)
      else $error("answer longer than one cycle");
   req_frame_a: assert property ($rose(req_valid) |-> req_valid [*3] ##1 !req_valid)
      else $error("request not held for exactly three cycles");
   words_stable_a: assert property (req_valid && $past(req_valid) |-> $stable(req_words))
      else $error("request words moved while pending");
   resp_hold_a: assert property (!resp_valid |-> $stable(resp_words))
      else $error("answer words moved between answers");
   // Contents of the answer
   answer_echo_a: assert property (resp_valid |-> resp_words[0][11:0] == req_words[0][11:0]
      && resp_words[1] == req_words[1]) else $error("answer does not echo number and index");
   bad_code_a: assert property (resp_valid && !(req_code inside {4'h6, 4'h7})
      |-> resp_code == 4'h7 && resp_words[2] == 16'h006A) else $error("unsupported code not refused");
   read_ok_a: assert property (resp_valid && req_code == 4'h6 && resp_code != 4'h7 |-> resp_code == 4'h5)
      else $error("read answered with wrong code");
   write_ok_a: assert property (resp_valid && req_code == 4'h7 && resp_code != 4'h7
      |-> resp_code == 4'h4 && resp_words[3:2] == req_words[3:2]) else $error("write answer malformed");
   err_form_a: assert property (resp_valid && resp_code == 4'h7 |-> resp_words[3] == 16'h0000)
      else $error("error answer low word not zero");
   unk_page_a: assert property (resp_valid && req_code inside {4'h6, 4'h7} && !page_ok
      |-> resp_code == 4'h7 && resp_words[2] == 16'h0000) else $error("unknown page not refused");
endmodule // pcr_assertions

// *** pcr_consts.svh ***
// Constants shared by both ends of the parameter channel request decoder
// Contract
// - Four 16-bit words: identifier, index, high, low
// - Code bits 15..12; code 6 reads
// - Code 7 changes a word parameter
// - Number field bits 10..0, offset removed
// - Full number is field plus page offset
// - Page index 90 hex selects offset 6000
// - Numbers below 1999 use page zero
// - Subindex sits in index bits 15..8
// - Page index sits in index bits 7..0
// - Controller sends subindex 0 if unindexed; the controller passes the loaded index word unchanged
// - Reads ignore value words; controller zeroes them
// - Numeric write: high word bits 31..16
// - Connector: source number, object code 3F
// - Connector low bits 9..0 hold source index
// - Selected telegram connections stay locked
// - Selection 999 first, then extended selection
// - Extended mode frees extra send map words
// - Failure answers code 7 with error number
// - Unknown parameter answers error 00 hex
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH
`define PCR_W_ID 0
`define PCR_W_IND 1
`define PCR_W_HI 2
`define PCR_W_LO 3
`define PCR_CODE_MSB 15
`define PCR_CODE_LSB 12
`define PCR_PNU_MSB 10
`define PCR_SUB_MSB 15
`define PCR_SUB_LSB 8
`define PCR_PAGE_MSB 7
`define PCR_DO_MSB 15
`define PCR_DO_LSB 10
`define PCR_CONN_IDX_MSB 9
`define PCR_DO_CODE 6'h3F
`define PCR_REQ_READ 4'h6
`define PCR_REQ_WRITE 4'h7
`define PCR_RESP_WORD 4'h4
`define PCR_RESP_DWORD 4'h5
`define PCR_RESP_ERR 4'h7
`define PCR_ERR_NO_PARAM 16'h0000
`define PCR_ERR_LOCKED 16'h0001
`define PCR_ERR_SUBIDX 16'h0003
`define PCR_ERR_NO_ARRAY 16'h0004
`define PCR_ERR_TYPE 16'h0005
`define PCR_ERR_VALUE 16'h0014
`define PCR_ERR_UNSUP 16'h006A
`define PCR_P_TG_SEL 16'h039A
`define PCR_P_EXT_SEL 16'h081F
`define PCR_P_RX_MAP 16'h0802
`define PCR_P_TX_MAP 16'h0803
`define PCR_TG_FREE 16'h03E7
`define PCR_TG_STD1 16'h0001
`define PCR_TG_STD20 16'h0014
`define PCR_TG_350 16'h015E
`define PCR_TG_352 16'h0160
`define PCR_TG_353 16'h0161
`define PCR_TG_354 16'h0162
`define PCR_BASE_BAD 4'hF
`define PCR_MAP_N 8
`define PCR_PAGE_0 8'h00
`define PCR_PAGE_2K 8'h80
`define PCR_PAGE_6K 8'h90
`define PCR_PAGE_8K 8'h20
`define PCR_PAGE_10K 8'hA0
`define PCR_PAGE_20K 8'h50
`define PCR_PAGE_30K 8'hF0
`define PCR_PAGE_60K 8'h74
`define PCR_OFS_0 16'h0000
`define PCR_OFS_2K 16'h07D0
`define PCR_OFS_6K 16'h1770
`define PCR_OFS_8K 16'h1F40
`define PCR_OFS_10K 16'h2710
`define PCR_OFS_20K 16'h4E20
`define PCR_OFS_30K 16'h7530
`define PCR_OFS_60K 16'hEA60
`define PCR_A_REQ0 8'h00
`define PCR_A_CTRL 8'h10
`define PCR_A_STAT 8'h14
`define PCR_A_RESP0 8'h18
`define PCR_A_LAST 8'h24
`define PCR_CTRL_GO 0
`define PCR_STAT_BUSY 0
`define PCR_STAT_DONE 1
`endif

// *** pcr_controller.sv ***
// Controller end: APB registers that issue requests and hold responses
`timescale 1ns/10ps
`include "pcr_consts.svh"
module pcr_controller (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   pcr_if.ctrl chan
);
   import pcr_pkg::*;

   typedef enum logic {ST_IDLE, ST_WAIT} pcr_ctl_state_t;

   pcr_ctl_state_t state_reg, state_next;
   pcr_chan_t req_reg, req_next;
   pcr_chan_t resp_reg, resp_next;
   logic done_reg, done_next;
   logic [31:0] rdata_reg, rdata_next;
   logic setup;
   logic wr_acc;
   logic mapped;
   logic [3:0] word_sel;

   assign setup = psel_in && !penable_in;
   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign word_sel = paddr_in[5:2];
   assign mapped = (paddr_in <= `PCR_A_LAST) && (paddr_in[1:0] == 2'b00);

   // Register updates and request sequencing
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      resp_next = resp_reg;
      done_next = done_reg;
      rdata_next = rdata_reg;
      if (setup) begin
         rdata_next = 32'h0000_0000;
         if (paddr_in < `PCR_A_CTRL) begin
            rdata_next = {16'h0000, req_reg[word_sel[1:0]]};
         end else if (paddr_in == `PCR_A_STAT) begin
            rdata_next = {30'h0000_0000, done_reg, state_reg == ST_WAIT};
         end else if (paddr_in >= `PCR_A_RESP0 && mapped) begin
            rdata_next = {16'h0000, resp_reg[2'(word_sel - 4'h6)]};
         end
      end
      unique case (state_reg)
         ST_IDLE: begin
            // Request words frozen while a request is outstanding
            if (wr_acc && paddr_in < `PCR_A_CTRL) begin
               req_next[word_sel[1:0]] = pwdata_in[15:0];
            end
            if (wr_acc && paddr_in == `PCR_A_CTRL && pwdata_in[`PCR_CTRL_GO]) begin
               if (req_reg[`PCR_W_ID][`PCR_CODE_MSB:`PCR_CODE_LSB] == `PCR_REQ_READ) begin
                  req_next[`PCR_W_HI] = 16'h0000;
                  req_next[`PCR_W_LO] = 16'h0000;
               end
               done_next = 1'b0;
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (chan.resp_valid) begin
               resp_next = chan.resp_words;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= ST_IDLE;
         req_reg <= '0;
         resp_reg <= '0;
         done_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         resp_reg <= resp_next;
         done_reg <= done_next;
         rdata_reg <= rdata_next;
      end
   end

   // Zero wait state slave; control and unmapped reads return zero, except unaligned addresses below 10 hex, which return a request word
   assign pready_out = psel_in && penable_in;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign prdata_out = rdata_reg;
   assign chan.req_valid = (state_reg == ST_WAIT);
   assign chan.req_words = req_reg;
endmodule // pcr_controller

// *** pcr_device.sv ***
// Device end: decodes and executes parameter channel requests
`timescale 1ns/10ps
`include "pcr_consts.svh"
module pcr_device (
   input wire logic clk_in,
   input wire logic reset_in,
   pcr_if.dev chan,
   input wire pcr_pkg::pcr_rx_t rx_words_in,
   output pcr_pkg::pcr_word_t tg_sel_out,
   output pcr_pkg::pcr_word_t ext_sel_out,
   output pcr_pkg::pcr_map_t send_map_out,
   output logic free_mode_out
);
   import pcr_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_ANSWER, ST_DRAIN} pcr_dev_state_t;

   pcr_dev_state_t state_reg, state_next;
   pcr_chan_t req_reg, req_next;
   pcr_chan_t resp_reg, resp_next;
   pcr_word_t tg_reg, tg_next;
   pcr_word_t ext_reg, ext_next;
   pcr_map_t map_reg, map_next;

   logic [3:0] code;
   logic [10:0] param_number_field;
   logic [7:0] sub;
   logic [7:0] page;
   logic [15:0] offset;
   logic page_ok;
   logic [15:0] full_num;
   logic [31:0] value;
   logic [3:0] base_cnt;
   logic [3:0] new_base;
   logic sub_in_map;
   logic err;
   logic [15:0] err_num;
   logic [31:0] rd_val;
   logic wr_tg;
   logic wr_ext;
   logic wr_map;

   // Field split of the latched request
   always_comb begin
      code = req_reg[`PCR_W_ID][`PCR_CODE_MSB:`PCR_CODE_LSB];
      param_number_field = req_reg[`PCR_W_ID][`PCR_PNU_MSB:0];
      sub = req_reg[`PCR_W_IND][`PCR_SUB_MSB:`PCR_SUB_LSB];
      page = req_reg[`PCR_W_IND][`PCR_PAGE_MSB:0];
      value = {req_reg[`PCR_W_HI], req_reg[`PCR_W_LO]};
      sub_in_map = (sub < 8'(`PCR_MAP_N));
   end

   pcr_page_offset u_page (
      .page_in(page),
      .offset_out(offset),
      .valid_out(page_ok)
   );

   // Full number: field plus page offset
   assign full_num = 16'(offset + {5'h00, param_number_field});

   // Number of send words fixed by a standard telegram; those stay locked
   function automatic logic [3:0] base_of(input logic [15:0] tg);
      unique case (tg)
         `PCR_TG_STD1: base_of = 4'h2;
         `PCR_TG_STD20: base_of = 4'h6;
         `PCR_TG_350: base_of = 4'h4;
         `PCR_TG_352: base_of = 4'h6;
         `PCR_TG_353: base_of = 4'h2;
         `PCR_TG_354: base_of = 4'h6;
         `PCR_TG_FREE: base_of = 4'h0;
         default: base_of = `PCR_BASE_BAD;
      endcase
   endfunction

   assign base_cnt = base_of(ext_reg);
   assign new_base = base_of(req_reg[`PCR_W_LO]);

   // Request execution; only reads, never commits state by itself
   always_comb begin
      err = 1'b0;
      err_num = `PCR_ERR_NO_PARAM;
      rd_val = 32'h0000_0000;
      wr_tg = 1'b0;
      wr_ext = 1'b0;
      wr_map = 1'b0;
      if (code != `PCR_REQ_READ && code != `PCR_REQ_WRITE) begin
         err = 1'b1;
         err_num = `PCR_ERR_UNSUP;
      end else if (!page_ok) begin
         err = 1'b1;
      end else begin
         unique case (full_num)
            `PCR_P_TG_SEL: begin
               rd_val = {16'h0000, tg_reg};
               if (sub != 8'h00) begin
                  err = 1'b1;
                  err_num = `PCR_ERR_NO_ARRAY;
               end else begin
                  wr_tg = (code == `PCR_REQ_WRITE);
               end
            end
            `PCR_P_EXT_SEL: begin
               rd_val = {16'h0000, ext_reg};
               if (sub != 8'h00) begin
                  err = 1'b1;
                  err_num = `PCR_ERR_NO_ARRAY;
               end else if (code == `PCR_REQ_WRITE) begin
                  if (tg_reg != `PCR_TG_FREE) begin
                     err = 1'b1;
                     err_num = `PCR_ERR_LOCKED;
                  end else if (new_base == `PCR_BASE_BAD) begin
                     err = 1'b1;
                     err_num = `PCR_ERR_VALUE;
                  end else begin
                     wr_ext = 1'b1;
                  end
               end
            end
            `PCR_P_RX_MAP: begin
               if (!sub_in_map) begin
                  err = 1'b1;
                  err_num = `PCR_ERR_SUBIDX;
               end else if (code == `PCR_REQ_WRITE) begin
                  err = 1'b1; // Display only
                  err_num = `PCR_ERR_LOCKED;
               end else begin
                  rd_val = {16'h0000, rx_words_in[sub[2:0]]};
               end
            end
            `PCR_P_TX_MAP: begin
               if (!sub_in_map) begin
                  err = 1'b1;
                  err_num = `PCR_ERR_SUBIDX;
               end else begin
                  rd_val = map_reg[sub[2:0]];
                  if (code == `PCR_REQ_WRITE) begin
                     if (tg_reg != `PCR_TG_FREE || base_cnt == `PCR_BASE_BAD || sub[3:0] < base_cnt) begin
                        err = 1'b1;
                        err_num = `PCR_ERR_LOCKED;
                     end else if (req_reg[`PCR_W_LO][`PCR_DO_MSB:`PCR_DO_LSB] != `PCR_DO_CODE) begin
                        err = 1'b1;
                        err_num = `PCR_ERR_TYPE;
                     end else begin
                        wr_map = 1'b1;
                     end
                  end
               end
            end
            default: begin
               err = 1'b1;
               err_num = `PCR_ERR_NO_PARAM;
            end
         endcase
      end
   end

   // Handshake: latch, execute, answer once, wait for request to drop
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      resp_next = resp_reg;
      tg_next = tg_reg;
      ext_next = ext_reg;
      map_next = map_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (chan.req_valid) begin
               req_next = chan.req_words;
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            resp_next[`PCR_W_ID] = {`PCR_RESP_WORD, req_reg[`PCR_W_ID][11:0]};
            resp_next[`PCR_W_IND] = req_reg[`PCR_W_IND];
            if (err) begin
               resp_next[`PCR_W_ID][`PCR_CODE_MSB:`PCR_CODE_LSB] = `PCR_RESP_ERR;
               resp_next[`PCR_W_HI] = err_num;
               resp_next[`PCR_W_LO] = 16'h0000;
            end else if (code == `PCR_REQ_READ) begin
               // Value words of a read are never looked at
               resp_next[`PCR_W_ID][`PCR_CODE_MSB:`PCR_CODE_LSB] = `PCR_RESP_DWORD;
               resp_next[`PCR_W_HI] = rd_val[31:16];
               resp_next[`PCR_W_LO] = rd_val[15:0];
            end else begin
               resp_next[`PCR_W_HI] = value[31:16];
               resp_next[`PCR_W_LO] = value[15:0];
            end
            if (!err && wr_tg) begin
               tg_next = value[15:0];
            end
            if (!err && wr_ext) begin
               ext_next = value[15:0];
            end
            if (!err && wr_map) begin
               // Source number and index kept as one connector word
               map_next[sub[2:0]] = {value[31:16], 6'h00, value[`PCR_CONN_IDX_MSB:0]};
            end
            state_next = ST_ANSWER;
         end
         ST_ANSWER: state_next = ST_DRAIN;
         ST_DRAIN: begin
            // A held request is not executed twice
            if (!chan.req_valid) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= ST_IDLE;
         req_reg <= '0;
         resp_reg <= '0;
         tg_reg <= `PCR_TG_STD1;
         ext_reg <= `PCR_TG_STD1;
         map_reg <= '0;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         resp_reg <= resp_next;
         tg_reg <= tg_next;
         ext_reg <= ext_next;
         map_reg <= map_next;
      end
   end

   // One pulse per executed request
   assign chan.resp_valid = (state_reg == ST_ANSWER);
   assign chan.resp_words = resp_reg;
   assign tg_sel_out = tg_reg;
   assign ext_sel_out = ext_reg;
   assign send_map_out = map_reg;
   assign free_mode_out = (tg_reg == `PCR_TG_FREE);
endmodule // pcr_device

// *** pcr_if.sv ***
// Parameter channel link between the master controller and the device
`timescale 1ns/10ps
interface pcr_if;
   import pcr_pkg::*;
   logic req_valid;
   pcr_chan_t req_words;
   logic resp_valid;
   pcr_chan_t resp_words;
   modport ctrl (output req_valid, output req_words, input resp_valid, input resp_words);
   modport dev (input req_valid, input req_words, output resp_valid, output resp_words);
endinterface

// *** pcr_page_offset.sv ***
// Page index to parameter number offset lookup
`timescale 1ns/10ps
`include "pcr_consts.svh"
module pcr_page_offset (
   input wire logic [7:0] page_in,
   output logic [15:0] offset_out,
   output logic valid_out
);
   import pcr_pkg::*;

   // Unknown page codes flag invalid so the number is treated as absent
   always_comb begin
      valid_out = 1'b1;
      unique case (page_in)
         `PCR_PAGE_0: offset_out = `PCR_OFS_0;
         `PCR_PAGE_2K: offset_out = `PCR_OFS_2K;
         `PCR_PAGE_6K: offset_out = `PCR_OFS_6K;
         `PCR_PAGE_8K: offset_out = `PCR_OFS_8K;
         `PCR_PAGE_10K: offset_out = `PCR_OFS_10K;
         `PCR_PAGE_20K: offset_out = `PCR_OFS_20K;
         `PCR_PAGE_30K: offset_out = `PCR_OFS_30K;
         `PCR_PAGE_60K: offset_out = `PCR_OFS_60K;
         default: begin
            offset_out = `PCR_OFS_0;
            valid_out = 1'b0;
         end
      endcase
   end
endmodule // pcr_page_offset

// *** pcr_pkg.sv ***
// Types shared by both ends of the parameter channel
package pcr_pkg;
   typedef logic [15:0] pcr_word_t;
   typedef logic [3:0][15:0] pcr_chan_t;
   typedef logic [7:0][31:0] pcr_map_t;
   typedef logic [7:0][15:0] pcr_rx_t;
endpackage
